/* File: src/tvic_regs.vh */
/*
 register offsets, field positions, reset values and vectors of the
 two-level vectored interrupt controller; assumes nothing beyond a verilog-2005 reader.
*/
`ifndef TVIC_REGS_VH
`define TVIC_REGS_VH

// special-function register addresses
`define TVIC_ADDR_PRI_EN 8'hA8
`define TVIC_ADDR_SEC_EP 8'hA9
`define TVIC_ADDR_PRI_PRIO 8'hB8

// reset values
`define TVIC_RST_PRI_EN 8'h00
`define TVIC_RST_PRI_PRIO 8'h00
`define TVIC_RST_SEC_EP 8'hA0

// primary enable field positions
`define TVIC_BIT_GLOBAL 7
`define TVIC_BIT_CONV 6
`define TVIC_BIT_TMR2 5
`define TVIC_BIT_UART 4
`define TVIC_BIT_TMR1 3
`define TVIC_BIT_EXT1 2
`define TVIC_BIT_TMR0 1
`define TVIC_BIT_EXT0 0

// secondary register field positions
`define TVIC_BIT_INTV_PRIO 6
`define TVIC_BIT_SMON_PRIO 5
`define TVIC_BIT_SIF_PRIO 4
`define TVIC_BIT_SEC_RSVD 3
`define TVIC_BIT_INTV_EN 2
`define TVIC_BIT_SMON_EN 1
`define TVIC_BIT_SIF_EN 0

// writable masks
`define TVIC_MASK_PRI_PRIO 8'h7F
`define TVIC_MASK_SEC_EP 8'h77

// polling index, 0 polled first
`define TVIC_SRC_SMON 4'h0
`define TVIC_SRC_WDOG 4'h1
`define TVIC_SRC_EXT0 4'h2
`define TVIC_SRC_CONV 4'h3
`define TVIC_SRC_TMR0 4'h4
`define TVIC_SRC_EXT1 4'h5
`define TVIC_SRC_TMR1 4'h6
`define TVIC_SRC_SIF 4'h7
`define TVIC_SRC_UART 4'h8
`define TVIC_SRC_TMR2 4'h9
`define TVIC_SRC_INTV 4'hA
`define TVIC_NUM_SRC 11

// vector addresses
`define TVIC_VEC_EXT0 16'h0003
`define TVIC_VEC_TMR0 16'h000B
`define TVIC_VEC_EXT1 16'h0013
`define TVIC_VEC_TMR1 16'h001B
`define TVIC_VEC_UART 16'h0023
`define TVIC_VEC_TMR2 16'h002B
`define TVIC_VEC_CONV 16'h0033
`define TVIC_VEC_SIF 16'h003B
`define TVIC_VEC_SMON 16'h0043
`define TVIC_VEC_INTV 16'h0053
`define TVIC_VEC_WDOG 16'h005B

`endif

/* File: src/tvic_ctrl.v */
/*
 two-level vectored interrupt controller: three special-function registers,
 eleven sources resolved by level and polling order, vector request to the core.
 assumes a core on the same clock that writes/reads registers over a byte port,
 acknowledges a vector request with irq_ack_i, and pulses reti_i on return.
*/
// Operation
// - global enable low blocks every maskable source
// - primary enable bits gate converter, timers, uart and external sources
// - primary priority bits put each source high when one; bit 7 reserved
// - secondary bits 6..4 set interval, supply monitor, serial priority
// - secondary bits 2..0 enable interval, supply monitor, serial interrupts
// - secondary register resets to A0H, primary priority to 00H
// - pending high-level request may preempt a low-level service routine
// - simultaneous requests of different levels: high level granted first
// - request never preempts a routine running at its own level
// - same-level requests polled in fixed order, supply monitor first
// - on acceptance core pushes counter then loads the granted vector
// - each source has its fixed vector address
// - watchdog timeout raises interrupt instead of reset when select is one
// - watchdog interrupt always at high level
// - watchdog interrupt ignores global enable
// - watchdog interrupts only when configured timeout exceeds zero
`include "tvic_regs.vh"
`default_nettype none

module tvic_ctrl (
  // clock, reset, enable
  input wire clk_sys,
  input wire nrst,
  input wire clk_en,
  // register port
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_hit_o,
  // source flags
  input wire supply_mon_flag,
  input wire watchdog_timeout_flag,
  input wire ext0_flag,
  input wire ext1_flag,
  input wire primary_conv_done,
  input wire aux_conv_done,
  input wire timer0_overflow,
  input wire timer1_overflow,
  input wire timer2_overflow,
  input wire timer2_external_flag,
  input wire two_wire_flag,
  input wire serial_periph_flag,
  input wire uart_receive_flag,
  input wire uart_transmit_flag,
  input wire interval_counter_flag,
  // watchdog configuration
  input wire watchdog_irq_select,
  input wire [3:0] watchdog_timeout_cfg,
  // core handshake
  input wire irq_ack_i,
  input wire reti_i,
  output reg irq_req_o,
  output reg [15:0] irq_vector_o,
  output reg [3:0] irq_source_o,
  output reg push_pc_o,
  output reg wdog_reset_o,
  output reg [1:0] in_service_o
);

  reg [7:0] primary_irq_enable_reg;
  reg [7:0] primary_irq_priority_reg;
  reg [7:0] secondary_irq_enable_priority_reg;
  reg [1:0] in_service_reg;
  reg [1:0] in_service_next;
  reg [10:0] pend;
  reg [10:0] level_hi;
  reg [3:0] pick;
  reg pick_hi;
  reg pick_ok;
  reg [7:0] rdata_next;
  reg hit_next;
  integer i;

  // fixed vector of a polling index
  function [15:0] vec_of;
    input [3:0] src;
    begin
      case (src)
        `TVIC_SRC_SMON: vec_of = `TVIC_VEC_SMON;
        `TVIC_SRC_WDOG: vec_of = `TVIC_VEC_WDOG;
        `TVIC_SRC_EXT0: vec_of = `TVIC_VEC_EXT0;
        `TVIC_SRC_CONV: vec_of = `TVIC_VEC_CONV;
        `TVIC_SRC_TMR0: vec_of = `TVIC_VEC_TMR0;
        `TVIC_SRC_EXT1: vec_of = `TVIC_VEC_EXT1;
        `TVIC_SRC_TMR1: vec_of = `TVIC_VEC_TMR1;
        `TVIC_SRC_SIF: vec_of = `TVIC_VEC_SIF;
        `TVIC_SRC_UART: vec_of = `TVIC_VEC_UART;
        `TVIC_SRC_TMR2: vec_of = `TVIC_VEC_TMR2;
        default: vec_of = `TVIC_VEC_INTV;
      endcase
    end
  endfunction

  wire global_irq_enable = primary_irq_enable_reg[`TVIC_BIT_GLOBAL];
  // watchdog takes the interrupt path only in interrupt mode with a live timeout
  wire wdog_irq = watchdog_timeout_flag && watchdog_irq_select && (watchdog_timeout_cfg != 4'h0);
  wire wdog_rst = watchdog_timeout_flag && !watchdog_irq_select;

  // pending, enabled requests in polling order
  always @* begin
    pend = 11'h000;
    pend[`TVIC_SRC_SMON] = supply_mon_flag && secondary_irq_enable_priority_reg[`TVIC_BIT_SMON_EN];
    pend[`TVIC_SRC_WDOG] = wdog_irq;
    pend[`TVIC_SRC_EXT0] = ext0_flag && primary_irq_enable_reg[`TVIC_BIT_EXT0];
    pend[`TVIC_SRC_CONV] = (primary_conv_done || aux_conv_done) && primary_irq_enable_reg[`TVIC_BIT_CONV];
    pend[`TVIC_SRC_TMR0] = timer0_overflow && primary_irq_enable_reg[`TVIC_BIT_TMR0];
    pend[`TVIC_SRC_EXT1] = ext1_flag && primary_irq_enable_reg[`TVIC_BIT_EXT1];
    pend[`TVIC_SRC_TMR1] = timer1_overflow && primary_irq_enable_reg[`TVIC_BIT_TMR1];
    pend[`TVIC_SRC_SIF] = (two_wire_flag || serial_periph_flag) && secondary_irq_enable_priority_reg[`TVIC_BIT_SIF_EN];
    pend[`TVIC_SRC_UART] = (uart_receive_flag || uart_transmit_flag) && primary_irq_enable_reg[`TVIC_BIT_UART];
    pend[`TVIC_SRC_TMR2] = (timer2_overflow || timer2_external_flag) && primary_irq_enable_reg[`TVIC_BIT_TMR2];
    pend[`TVIC_SRC_INTV] = interval_counter_flag && secondary_irq_enable_priority_reg[`TVIC_BIT_INTV_EN];
    if (!global_irq_enable) begin
      pend = pend & (11'h001 << `TVIC_SRC_WDOG);
    end
  end

  // level of each source
  always @* begin
    level_hi = 11'h000;
    level_hi[`TVIC_SRC_SMON] = secondary_irq_enable_priority_reg[`TVIC_BIT_SMON_PRIO];
    level_hi[`TVIC_SRC_WDOG] = 1'b1;
    level_hi[`TVIC_SRC_EXT0] = primary_irq_priority_reg[`TVIC_BIT_EXT0];
    level_hi[`TVIC_SRC_CONV] = primary_irq_priority_reg[`TVIC_BIT_CONV];
    level_hi[`TVIC_SRC_TMR0] = primary_irq_priority_reg[`TVIC_BIT_TMR0];
    level_hi[`TVIC_SRC_EXT1] = primary_irq_priority_reg[`TVIC_BIT_EXT1];
    level_hi[`TVIC_SRC_TMR1] = primary_irq_priority_reg[`TVIC_BIT_TMR1];
    level_hi[`TVIC_SRC_SIF] = secondary_irq_enable_priority_reg[`TVIC_BIT_SIF_PRIO];
    level_hi[`TVIC_SRC_UART] = primary_irq_priority_reg[`TVIC_BIT_UART];
    level_hi[`TVIC_SRC_TMR2] = primary_irq_priority_reg[`TVIC_BIT_TMR2];
    level_hi[`TVIC_SRC_INTV] = secondary_irq_enable_priority_reg[`TVIC_BIT_INTV_PRIO];
  end

  // level first, then polling order; walk backwards so the lowest index wins
  always @* begin
    pick = 4'h0;
    pick_hi = 1'b0;
    pick_ok = 1'b0;
    for (i = `TVIC_NUM_SRC - 1; i >= 0; i = i - 1) begin
      if (pend[i] && !level_hi[i] && !(|(pend & level_hi))) begin
        pick = i[3:0];
        pick_ok = 1'b1;
      end
    end
    for (i = `TVIC_NUM_SRC - 1; i >= 0; i = i - 1) begin
      if (pend[i] && level_hi[i]) begin
        pick = i[3:0];
        pick_hi = 1'b1;
        pick_ok = 1'b1;
      end
    end
    // high may preempt low; nothing preempts high; same level never preempts
    if (in_service_reg[1] || (in_service_reg[0] && !pick_hi)) begin
      pick_ok = 1'b0;
    end
  end

  // in-service stack of levels; a return and an acceptance in one cycle both take effect, the set last
  always @* begin
    in_service_next = in_service_reg;
    if (reti_i) begin
      if (in_service_reg[1]) begin
        in_service_next[1] = 1'b0;
      end else begin
        in_service_next[0] = 1'b0;
      end
    end
    if (irq_req_o && irq_ack_i) begin
      if (irq_source_o == `TVIC_SRC_WDOG || level_hi[irq_source_o]) begin
        in_service_next[1] = 1'b1;
      end else begin
        in_service_next[0] = 1'b1;
      end
    end
  end

  // register read decode
  always @* begin
    rdata_next = 8'h00;
    hit_next = 1'b1;
    case (reg_addr_i)
      `TVIC_ADDR_PRI_EN: rdata_next = primary_irq_enable_reg;
      `TVIC_ADDR_PRI_PRIO: rdata_next = primary_irq_priority_reg;
      `TVIC_ADDR_SEC_EP: rdata_next = secondary_irq_enable_priority_reg;
      default: hit_next = 1'b0;
    endcase
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      primary_irq_enable_reg <= `TVIC_RST_PRI_EN;
      primary_irq_priority_reg <= `TVIC_RST_PRI_PRIO;
      secondary_irq_enable_priority_reg <= `TVIC_RST_SEC_EP;
      in_service_reg <= 2'b00;
      reg_rdata_o <= 8'h00;
      reg_hit_o <= 1'b0;
      irq_req_o <= 1'b0;
      irq_vector_o <= 16'h0000;
      irq_source_o <= 4'h0;
      push_pc_o <= 1'b0;
      wdog_reset_o <= 1'b0;
      in_service_o <= 2'b00;
    end else if (clk_en) begin
      if (reg_wr_i) begin
        case (reg_addr_i)
          `TVIC_ADDR_PRI_EN: primary_irq_enable_reg <= reg_wdata_i;
          `TVIC_ADDR_PRI_PRIO: primary_irq_priority_reg <= reg_wdata_i & `TVIC_MASK_PRI_PRIO;
          // reserved bit 7 stays one, bit 3 is forced to zero by the write mask
          `TVIC_ADDR_SEC_EP: secondary_irq_enable_priority_reg <=
            (reg_wdata_i & `TVIC_MASK_SEC_EP) | `TVIC_RST_SEC_EP & 8'h80;
          default: ;
        endcase
      end
      reg_rdata_o <= reg_rd_i ? rdata_next : 8'h00;
      reg_hit_o <= (reg_rd_i || reg_wr_i) && hit_next;
      in_service_reg <= in_service_next;
      in_service_o <= in_service_next;
      wdog_reset_o <= wdog_rst;
      // request held until acknowledged, then one-cycle push marker
      push_pc_o <= irq_req_o && irq_ack_i;
      if (irq_req_o && irq_ack_i) begin
        irq_req_o <= 1'b0;
      end else if (!irq_req_o) begin
        irq_req_o <= pick_ok;
        irq_source_o <= pick;
        irq_vector_o <= vec_of(pick);
      end
    end
  end

endmodule
`default_nettype wire

/* File: bench/tvic_ctrl_checker.sv */
/*
 port assertions for tvic_ctrl, bound to every instance;
 assumes clk_en is held high and one clock domain.
*/
`default_nettype none
module tvic_chk (
  // clock and reset
  input wire logic clk_sys, nrst,
  // register port
  input wire logic reg_rd_i, reg_hit_o,
  input wire logic [7:0] reg_addr_i, reg_rdata_o,
  // watchdog
  input wire logic watchdog_timeout_flag, watchdog_irq_select, wdog_reset_o,
  input wire logic [3:0] watchdog_timeout_cfg,
  // core handshake
  input wire logic irq_ack_i, reti_i, irq_req_o, push_pc_o,
  input wire logic [15:0] irq_vector_o,
  input wire logic [3:0] irq_source_o,
  input wire logic [1:0] in_service_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // vectors in polling order
  localparam logic [15:0] VT [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
    16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_req_hold: assert property (irq_req_o && !irq_ack_i |=> irq_req_o && $stable(irq_vector_o))
    else $error("request dropped or vector moved before ack");
  a_ack_push: assert property (irq_req_o && irq_ack_i |=> push_pc_o && !irq_req_o ##1 !push_pc_o)
    else $error("no single push pulse after ack");
  a_vec_map: assert property (irq_req_o |-> irq_source_o < 11 && irq_vector_o == VT[irq_source_o])
    else $error("vector does not match source");
  a_wdog_reset: assert property (1 |=> wdog_reset_o == ($past(watchdog_timeout_flag) && !$past(watchdog_irq_select)))
    else $error("watchdog reset output wrong");
  a_wdog_cfg: assert property ($rose(irq_req_o) && irq_source_o == 4'h1
    |-> $past(watchdog_timeout_cfg) != 0 && $past(watchdog_irq_select))
    else $error("watchdog interrupt without select or timeout");
  a_wdog_high: assert property (push_pc_o && $past(irq_source_o) == 4'h1 |-> in_service_o[1])
    else $error("watchdog not serviced at high level");
  a_level_block: assert property (in_service_o[1] && $past(in_service_o[1]) |-> !$rose(irq_req_o))
    else $error("request raised during high level service");
  a_reti_pop: assert property (reti_i && in_service_o == 2'b11 |=> in_service_o == 2'b01)
    else $error("return did not pop high level only");
  a_reti_low: assert property (reti_i && in_service_o == 2'b01 && !(irq_req_o && irq_ack_i) |=> in_service_o == 2'b00)
    else $error("return did not pop low level");
  a_sec_fixed: assert property (reg_rd_i && reg_addr_i == 8'hA9 |=> reg_hit_o && reg_rdata_o[7] && !reg_rdata_o[3])
    else $error("secondary reserved bits wrong");
  c_nested: cover property (in_service_o == 2'b11);
  c_wdog: cover property (irq_req_o && irq_source_o == 4'h1);
  c_ret: cover property (reti_i && in_service_o == 2'b01);
endmodule
bind tvic_ctrl tvic_chk i_chk (.*);
`default_nettype wire

/* File: bench/tvic_core_model.sv */
/*
 behavioural core: acknowledges requests after a set delay and
 issues returns on command; assumes inputs change 1 ns after edges.
*/
`default_nettype none
module tvic_core_model (
  // clock, reset, commands
  input wire logic clk_sys, nrst, do_reti,
  input wire logic [7:0] ack_dly,
  // controller side
  input wire logic irq_req_o,
  input wire logic [15:0] irq_vector_o,
  output var logic irq_ack_i, reti_i,
  // record of taken vectors
  output var logic [15:0] taken_vec,
  output var int taken_n
);
  timeunit 1ns;
  timeprecision 100ps;
  int wait_c = 0;
  logic hit, go;
  initial begin
    irq_ack_i = 0;
    reti_i = 0;
    taken_n = 0;
    taken_vec = 0;
  end
  always @(posedge clk_sys) begin
    hit = irq_req_o && irq_ack_i;
    go = do_reti;
    if (hit) begin
      taken_vec = irq_vector_o;
      taken_n++;
    end
    wait_c = (irq_req_o && !hit) ? wait_c + 1 : 0;
    #1;
    irq_ack_i = nrst && irq_req_o && !hit && wait_c > ack_dly;
    reti_i = go;
  end
endmodule
`default_nettype wire

/* File: bench/test_tvic_ctrl.sv */
/*
 testbench for tvic_ctrl: register access, polling order, nesting,
 watchdog; assumes the core model answers the request handshake.
*/
`default_nettype none
module test_tvic_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 0, nrst = 0, rd = 0, wr = 0, sel = 0, do_reti = 0;
  logic [7:0] addr = 0, wdata = 0, ack_dly = 0, rdata;
  logic [14:0] f = 0;
  logic [3:0] cfg = 0, src;
  logic hit, req, ack, reti, push, wrst;
  logic [15:0] vec, tvec;
  logic [1:0] insv;
  int errors = 0, cmp_count = 0, tn;
  logic [15:0] ord_v [10] = '{16'h0043, 16'h0003, 16'h0033, 16'h000B, 16'h0013, 16'h001B, 16'h003B,
    16'h0023, 16'h002B, 16'h0053};
  int ord_f [10] = '{0, 2, 4, 5, 6, 7, 10, 13, 9, 14};
  initial forever #5 clk_sys = ~clk_sys;
  tvic_ctrl i_dut (.clk_sys, .nrst, .clk_en(1'b1), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_hit_o(hit), .supply_mon_flag(f[0]),
    .watchdog_timeout_flag(f[1]), .ext0_flag(f[2]), .primary_conv_done(f[3]), .aux_conv_done(f[4]),
    .timer0_overflow(f[5]), .ext1_flag(f[6]), .timer1_overflow(f[7]), .timer2_overflow(f[8]),
    .timer2_external_flag(f[9]), .two_wire_flag(f[10]), .serial_periph_flag(f[11]),
    .uart_receive_flag(f[12]), .uart_transmit_flag(f[13]), .interval_counter_flag(f[14]),
    .watchdog_irq_select(sel), .watchdog_timeout_cfg(cfg), .irq_ack_i(ack), .reti_i(reti),
    .irq_req_o(req), .irq_vector_o(vec), .irq_source_o(src), .push_pc_o(push), .wdog_reset_o(wrst),
    .in_service_o(insv));
  tvic_core_model i_core (.clk_sys, .nrst, .do_reti, .ack_dly, .irq_req_o(req), .irq_vector_o(vec),
    .irq_ack_i(ack), .reti_i(reti), .taken_vec(tvec), .taken_n(tn));
  task finish_test;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e, input logic h);
    tick(1);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    tick(1);
    wr = 0;
    rd = 0;
    if (!w) begin
      chk(rdata, e);
      chk(hit, h);
    end
  endtask
  task take(input logic [15:0] e);
    int n;
    n = tn;
    repeat (60) if (tn == n) tick(1);
    chk(tn != n, 1);
    chk(tvec, e);
  endtask
  task quiet;
    int n;
    n = tn;
    tick(10);
    chk(tn == n && !req, 1);
  endtask
  task reti_p;
    do_reti = 1;
    tick(1);
    do_reti = 0;
    tick(2);
  endtask
  initial begin
    tick(20);
    nrst = 1;
    acc(0, 8'hA8, 0, 8'h00, 1);
    acc(0, 8'hB8, 0, 8'h00, 1);
    acc(0, 8'hA9, 0, 8'hA0, 1);
    acc(0, 8'h55, 0, 8'h00, 0);
    acc(1, 8'hB8, 8'hFF, 0, 0);
    acc(0, 8'hB8, 0, 8'h7F, 1);
    acc(1, 8'hA9, 8'h77, 0, 0);
    acc(0, 8'hA9, 0, 8'hF7, 1);
    acc(1, 8'hB8, 8'h00, 0, 0);
    acc(1, 8'hA9, 8'h07, 0, 0);
    acc(1, 8'hA8, 8'h7F, 0, 0);
    f = 15'h66F5;
    quiet;
    ack_dly = 3;
    acc(1, 8'hA8, 8'hFF, 0, 0);
    for (int i = 0; i < 10; i++) begin
      take(ord_v[i]);
      f[ord_f[i]] = 0;
      reti_p;
    end
    ack_dly = 0;
    acc(1, 8'hB8, 8'h04, 0, 0);
    f[5] = 1;
    f[6] = 1;
    take(16'h0013);
    f[6] = 0;
    reti_p;
    take(16'h000B);
    f[5] = 0;
    f[2] = 1;
    quiet;
    f[6] = 1;
    take(16'h0013);
    f[6] = 0;
    reti_p;
    chk(insv, 2'b01);
    reti_p;
    take(16'h0003);
    f[2] = 0;
    reti_p;
    acc(1, 8'hA8, 8'h00, 0, 0);
    sel = 1;
    f[1] = 1;
    quiet;
    chk(wrst, 0);
    cfg = 4'h3;
    take(16'h005B);
    f[1] = 0;
    tick(1);
    chk(insv, 2'b10);
    reti_p;
    sel = 0;
    f[1] = 1;
    tick(2);
    chk(wrst, 1);
    f[1] = 0;
    finish_test;
  end
  initial begin
    #100us;
    errors++;
    finish_test;
  end
endmodule
`default_nettype wire
